// ### vco_cal_and_output_divider_sync.sv
// Purpose: vco calibration sequencing and 14-channel divider, delay and sync control
// Assumes: clk is the vco output divider clock; pfd_tick is a one-cycle strobe per pll2 pfd period
// Notes: register writes are staged and take effect when the commit bit is written
//
// Function
// - calibration starts when the calibrate bit goes 0 to 1; bit never self-clears.
// - read-only in-progress bit is 1 during calibration, clears when it finishes.
// - divider channels held in sync until first calibration, which then syncs them.
// - calibration lasts 400,000 pfd periods; host timeout covers it plus lock time.
// - fourteen channels, each sourced from pll1, pll2 or sysref.
// - coarse delay only through the divider; sysref retimed by divider for sync.
// - output sync synchronously resets every participating channel divider.
// - each divider divides 1 to 256 with duty-cycle correction near 50%.
// - 6-bit coarse offset in half periods, taken only at the next sync.
// - while sync bit is set, outputs not sourced from pll1 are off unless ignore-sync mask bit set.
// - per-channel fine delay enable and 4-bit code, 0000 min, 1111 max.
// - per-channel power-down holds output static; separate regulator power-down.
// - first pll2 lock after reset syncs the dividers once, later locks do not.
// - host sets then clears sync bit; sync happens on the 1-to-0 change.
// - calibration divider is 4 times b plus a; b 3..63, a 0..3, min 16.
`timescale 1ns/1ns
module vco_cal_and_output_divider_sync #(
  parameter int NUM_CH = clkdist_pkg::NUM_CH,
  parameter int CAL_PFD_PERIODS = clkdist_pkg::CAL_PFD_PERIODS
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic pfd_tick,
  input wire logic pll2_locked,
  input wire logic pll1_level,
  input wire logic sysref_level,
  input wire logic [NUM_CH-1:0][1:0] ch_source,
  input wire logic [NUM_CH-1:0][7:0] ch_divide,
  input wire logic [NUM_CH-1:0][5:0] ch_coarse,
  input wire logic [NUM_CH-1:0] ch_fine_en,
  input wire logic [NUM_CH-1:0][3:0] ch_fine_code,
  input wire logic [5:0] cal_b_count,
  input wire logic [1:0] cal_a_count,
  output logic [NUM_CH-1:0] output_channel,
  output logic [NUM_CH-1:0] fine_en_out,
  output logic [NUM_CH-1:0][3:0] fine_code_out,
  output logic [NUM_CH-1:0] half_step,
  output logic [NUM_CH-1:0] regulator_pd,
  output logic cal_busy,
  output logic cal_bad,
  output logic [7:0] cal_divider_value
);
  localparam int CW = $clog2(CAL_PFD_PERIODS + 1);
  localparam int HI_CH = NUM_CH - clkdist_pkg::LOW_CH;
  localparam logic [CW-1:0] CAL_LAST = CW'(CAL_PFD_PERIODS - 1);

  // ==========================================================
  // pin synchronisers
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic lock_s;
  logic pll1_s;
  logic sysref_s;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else if (ce) begin
      sync_a <= {sysref_level, pll1_level, pll2_locked};
      sync_b <= sync_a;
    end
  end
  assign lock_s = sync_b[0];
  assign pll1_s = sync_b[1];
  assign sysref_s = sync_b[2];

  // ==========================================================
  // register file: staged writes, committed together
  logic [7:0] stage [clkdist_pkg::REG_COUNT];
  logic [7:0] act [clkdist_pkg::REG_COUNT];
  logic [7:0] next_stage [clkdist_pkg::REG_COUNT];
  logic [7:0] next_act [clkdist_pkg::REG_COUNT];
  logic [7:0] next_reg_rdata;
  logic [7:0] status;
  always_comb begin
    next_stage = stage;
    next_act = act;
    next_reg_rdata = reg_rdata;
    if (reg_wr) begin
      case (reg_addr)
        clkdist_pkg::ADDR_COMMIT: begin
          if (reg_wdata[clkdist_pkg::BIT_COMMIT]) next_act = stage;
        end
        clkdist_pkg::ADDR_CAL: next_stage[clkdist_pkg::IDX_CAL] = reg_wdata;
        clkdist_pkg::ADDR_SYNC: next_stage[clkdist_pkg::IDX_SYNC] = reg_wdata;
        clkdist_pkg::ADDR_MASK_LO: next_stage[clkdist_pkg::IDX_MASK_LO] = reg_wdata;
        clkdist_pkg::ADDR_MASK_HI: next_stage[clkdist_pkg::IDX_MASK_HI] = reg_wdata;
        clkdist_pkg::ADDR_PD_LO: next_stage[clkdist_pkg::IDX_PD_LO] = reg_wdata;
        clkdist_pkg::ADDR_PD_HI: next_stage[clkdist_pkg::IDX_PD_HI] = reg_wdata;
        clkdist_pkg::ADDR_LDO_LO: next_stage[clkdist_pkg::IDX_LDO_LO] = reg_wdata;
        clkdist_pkg::ADDR_LDO_HI: next_stage[clkdist_pkg::IDX_LDO_HI] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        clkdist_pkg::ADDR_CAL: next_reg_rdata = stage[clkdist_pkg::IDX_CAL];
        clkdist_pkg::ADDR_SYNC: next_reg_rdata = stage[clkdist_pkg::IDX_SYNC];
        clkdist_pkg::ADDR_MASK_LO: next_reg_rdata = stage[clkdist_pkg::IDX_MASK_LO];
        clkdist_pkg::ADDR_MASK_HI: next_reg_rdata = stage[clkdist_pkg::IDX_MASK_HI];
        clkdist_pkg::ADDR_PD_LO: next_reg_rdata = stage[clkdist_pkg::IDX_PD_LO];
        clkdist_pkg::ADDR_PD_HI: next_reg_rdata = stage[clkdist_pkg::IDX_PD_HI];
        clkdist_pkg::ADDR_LDO_LO: next_reg_rdata = stage[clkdist_pkg::IDX_LDO_LO];
        clkdist_pkg::ADDR_LDO_HI: next_reg_rdata = stage[clkdist_pkg::IDX_LDO_HI];
        clkdist_pkg::ADDR_STATUS: next_reg_rdata = status;
        default: next_reg_rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < clkdist_pkg::REG_COUNT; k++) begin
        stage[k] <= clkdist_pkg::REG_RESET;
        act[k] <= clkdist_pkg::REG_RESET;
      end
      reg_rdata <= 8'h00;
    end else if (ce) begin
      stage <= next_stage;
      act <= next_act;
      reg_rdata <= next_reg_rdata;
    end
  end

  logic [NUM_CH-1:0] ignore_mask;
  logic [NUM_CH-1:0] pd_mask;
  logic [NUM_CH-1:0] ldo_mask;
  assign ignore_mask = {act[clkdist_pkg::IDX_MASK_HI][HI_CH-1:0], act[clkdist_pkg::IDX_MASK_LO]};
  assign pd_mask = {act[clkdist_pkg::IDX_PD_HI][HI_CH-1:0], act[clkdist_pkg::IDX_PD_LO]};
  assign ldo_mask = {act[clkdist_pkg::IDX_LDO_HI][HI_CH-1:0], act[clkdist_pkg::IDX_LDO_LO]};
  assign status = {6'h00, cal_bad, cal_busy};

  // ==========================================================
  // vco calibration sequencer
  clkdist_pkg::cal_state_t cal_state;
  clkdist_pkg::cal_state_t next_cal_state;
  logic [CW-1:0] cal_cnt;
  logic [CW-1:0] next_cal_cnt;
  logic cal_prev;
  logic cal_seen;
  logic cal_auto;
  logic next_cal_seen;
  logic next_cal_auto;
  logic next_cal_busy;
  logic next_cal_bad;
  logic [7:0] next_cal_divider_value;
  logic cal_level;
  assign cal_level = act[clkdist_pkg::IDX_CAL][clkdist_pkg::BIT_CAL];
  always_comb begin
    next_cal_state = cal_state;
    next_cal_cnt = cal_cnt;
    next_cal_seen = cal_seen;
    next_cal_auto = 1'b0;
    next_cal_busy = cal_busy;
    next_cal_divider_value = (clkdist_pkg::CAL_PRESCALE * {2'h0, cal_b_count}) + {6'h00, cal_a_count};
    next_cal_bad = (cal_b_count < clkdist_pkg::CAL_B_MIN) ||
                   (next_cal_divider_value < clkdist_pkg::CAL_DIV_MIN);
    case (cal_state)
      clkdist_pkg::CAL_IDLE: begin
        if (cal_level && !cal_prev) begin
          next_cal_state = clkdist_pkg::CAL_RUN;
          next_cal_cnt = '0;
          next_cal_busy = 1'b1;
        end
      end
      clkdist_pkg::CAL_RUN: begin
        if (pfd_tick) begin
          if (cal_cnt == CAL_LAST) begin
            next_cal_state = clkdist_pkg::CAL_IDLE;
            next_cal_busy = 1'b0;
            next_cal_seen = 1'b1;
            next_cal_auto = !cal_seen;
          end else begin
            next_cal_cnt = cal_cnt + 1'b1;
          end
        end
      end
      default: begin
        next_cal_state = clkdist_pkg::CAL_IDLE;
        next_cal_busy = 1'b0;
      end
    endcase
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cal_state <= clkdist_pkg::CAL_IDLE;
      cal_cnt <= '0;
      cal_prev <= 1'b0;
      cal_seen <= 1'b0;
      cal_auto <= 1'b0;
      cal_busy <= 1'b0;
      cal_bad <= 1'b0;
      cal_divider_value <= 8'h00;
    end else if (ce) begin
      cal_state <= next_cal_state;
      cal_cnt <= next_cal_cnt;
      cal_prev <= cal_level;
      cal_seen <= next_cal_seen;
      cal_auto <= next_cal_auto;
      cal_busy <= next_cal_busy;
      cal_bad <= next_cal_bad;
      cal_divider_value <= next_cal_divider_value;
    end
  end

  // ==========================================================
  // sync events
  logic sync_prev;
  logic lock_seen;
  logic sync_level;
  logic cmd_fall;
  logic lock_first;
  logic auto_evt;
  assign sync_level = act[clkdist_pkg::IDX_SYNC][clkdist_pkg::BIT_SYNC];
  assign cmd_fall = sync_prev && !sync_level;
  assign lock_first = lock_s && !lock_seen;
  assign auto_evt = cal_auto || lock_first;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_prev <= 1'b0;
      lock_seen <= 1'b0;
    end else if (ce) begin
      sync_prev <= sync_level;
      lock_seen <= lock_seen || lock_s;
    end
  end

  // ==========================================================
  // channel dividers
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic [7:0] cnt;
    logic [4:0] dly;
    logic run;
    logic srq;
    logic next_out;
    logic [7:0] next_cnt;
    logic [4:0] next_dly;
    logic next_run;
    logic next_half;
    logic next_srq;
    logic hold;
    logic part;
    logic [8:0] hi_len;
    logic div_hi;
    assign hold = (sync_level && !ignore_mask[i]) || !cal_seen;
    assign part = !ignore_mask[i] || auto_evt;
    assign hi_len = ({1'b0, ch_divide[i]} + 9'h002) >> 1;
    assign div_hi = run && ({1'b0, cnt} < hi_len);
    always_comb begin
      next_cnt = cnt;
      next_dly = dly;
      next_run = run;
      next_half = half_step[i];
      next_srq = srq;
      if (hold) begin
        next_cnt = 8'h00;
        next_run = 1'b0;
      end else if ((cmd_fall || auto_evt) && part) begin
        next_cnt = 8'h00;
        next_dly = ch_coarse[i][5:1];
        next_half = ch_coarse[i][0];
        next_run = (ch_coarse[i][5:1] == 5'h00);
      end else if (!run) begin
        // the last delay cycle starts the counter, so a delay of d costs d cycles
        if (dly <= 5'h01) begin
          next_run = 1'b1;
          next_dly = 5'h00;
        end else begin
          next_dly = dly - 5'h01;
        end
      end else begin
        next_cnt = (cnt == ch_divide[i]) ? 8'h00 : cnt + 8'h01;
      end
      if (run && cnt == 8'h00) next_srq = sysref_s;
      if (pd_mask[i] || ldo_mask[i]) begin
        next_out = 1'b0;
      end else if (ch_source[i] == clkdist_pkg::SRC_PLL1) begin
        next_out = pll1_s;
      end else if (hold) begin
        next_out = 1'b0;
      end else if (ch_source[i] == clkdist_pkg::SRC_SYSREF) begin
        next_out = srq;
      end else begin
        next_out = div_hi;
      end
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        cnt <= 8'h00;
        dly <= 5'h00;
        run <= 1'b0;
        srq <= 1'b0;
        half_step[i] <= 1'b0;
        output_channel[i] <= 1'b0;
        fine_en_out[i] <= 1'b0;
        fine_code_out[i] <= 4'h0;
        regulator_pd[i] <= 1'b0;
      end else if (ce) begin
        cnt <= next_cnt;
        dly <= next_dly;
        run <= next_run;
        srq <= next_srq;
        half_step[i] <= next_half;
        output_channel[i] <= next_out;
        fine_en_out[i] <= ch_fine_en[i];
        fine_code_out[i] <= ch_fine_code[i];
        regulator_pd[i] <= ldo_mask[i];
      end
    end
  end
endmodule : vco_cal_and_output_divider_sync

// ### clkdist_pkg.sv
// Purpose: shared constants for vco calibration and output divider sync control
// Assumes: byte-wide registers on the serial control port, 16-bit register addresses
// Notes: channel count and calibration length are defaults of top-level parameters
package clkdist_pkg;
  localparam int NUM_CH = 14;
  localparam int LOW_CH = 8;
  // register addresses
  localparam logic [15:0] ADDR_COMMIT = 16'h000f;
  localparam logic [15:0] ADDR_CAL = 16'h0203;
  localparam logic [15:0] ADDR_SYNC = 16'h032a;
  localparam logic [15:0] ADDR_MASK_LO = 16'h032b;
  localparam logic [15:0] ADDR_MASK_HI = 16'h032c;
  localparam logic [15:0] ADDR_PD_LO = 16'h0501;
  localparam logic [15:0] ADDR_PD_HI = 16'h0502;
  localparam logic [15:0] ADDR_LDO_LO = 16'h0503;
  localparam logic [15:0] ADDR_LDO_HI = 16'h0504;
  localparam logic [15:0] ADDR_STATUS = 16'h0509;
  // storage slots of the writable registers
  localparam int REG_COUNT = 8;
  localparam int IDX_CAL = 0;
  localparam int IDX_SYNC = 1;
  localparam int IDX_MASK_LO = 2;
  localparam int IDX_MASK_HI = 3;
  localparam int IDX_PD_LO = 4;
  localparam int IDX_PD_HI = 5;
  localparam int IDX_LDO_LO = 6;
  localparam int IDX_LDO_HI = 7;
  localparam logic [7:0] REG_RESET = 8'h00;
  // field positions
  localparam int BIT_COMMIT = 0;
  localparam int BIT_CAL = 0;
  localparam int BIT_SYNC = 0;
  localparam int BIT_BUSY = 0;
  localparam int BIT_CAL_BAD = 1;
  // channel source select codes
  localparam logic [1:0] SRC_PLL2 = 2'h0;
  localparam logic [1:0] SRC_PLL1 = 2'h1;
  localparam logic [1:0] SRC_SYSREF = 2'h2;
  // calibration feedback divider, length and states
  localparam logic [7:0] CAL_PRESCALE = 8'h04;
  localparam logic [5:0] CAL_B_MIN = 6'h03;
  localparam logic [7:0] CAL_DIV_MIN = 8'h10;
  localparam int CAL_PFD_PERIODS = 400000;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN = 2'b01
  } cal_state_t;
endpackage : clkdist_pkg

// ### pll2_side_model.sv
// Purpose: pll2 side of the block: phase detector ticks and lock level
// Assumes: reference present from reset, one tick every PERIOD cycles
// Notes: lock follows lock_req after two cycles, like a slow lock detector
`timescale 1ns/1ns
module pll2_side_model #(
  parameter int PERIOD = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic lock_req,
  output logic pfd_tick,
  output logic pll2_locked
);
  int cnt;
  logic lock_d;
  // ===========================================
  // tick and lock generation
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 0;
      pfd_tick <= 1'b0;
      lock_d <= 1'b0;
      pll2_locked <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      pfd_tick <= (cnt == PERIOD - 1);
      lock_d <= lock_req;
      pll2_locked <= lock_d;
    end
  end
endmodule : pll2_side_model

// ### vco_cal_sync_asserts.sv
// Purpose: concurrent checks on the calibration and divider sync block
// Assumes: ce held high, all channels sourced from the pll2 divider until the first calibration
// Notes: helper logic counts ticks during calibration and the first completion
`timescale 1ns/1ns
module vco_cal_sync_asserts #(
  parameter int NUM_CH = 14,
  parameter int CAL_PFD_PERIODS = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic pfd_tick,
  input wire logic [NUM_CH-1:0] ch_fine_en,
  input wire logic [NUM_CH-1:0][3:0] ch_fine_code,
  input wire logic [5:0] cal_b_count,
  input wire logic [1:0] cal_a_count,
  input wire logic [NUM_CH-1:0] output_channel,
  input wire logic [NUM_CH-1:0] fine_en_out,
  input wire logic [NUM_CH-1:0][3:0] fine_code_out,
  input wire logic cal_busy,
  input wire logic cal_bad,
  input wire logic [7:0] cal_divider_value
);
  logic [1:0] up;
  logic [1:0] next_up;
  int ticks;
  int next_ticks;
  logic was_busy;
  logic next_was_busy;
  logic seen;
  logic next_seen;
  // ===========================================
  // helper state
  always_comb begin
    next_up = (up == 2'h3) ? up : up + 2'h1;
    next_ticks = cal_busy ? ticks + (pfd_tick ? 1 : 0) : 0;
    next_was_busy = cal_busy;
    next_seen = seen | (was_busy & ~cal_busy);
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      up <= 2'h0;
      ticks <= 0;
      was_busy <= 1'b0;
      seen <= 1'b0;
    end else begin
      up <= next_up;
      ticks <= next_ticks;
      was_busy <= next_was_busy;
      seen <= next_seen;
    end
  end
  // ===========================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_div_value: assert property (up == 2'h3 |->
    cal_divider_value == {$past(cal_b_count), 2'h0} + 8'($past(cal_a_count)))
    else $error("calibration divider value wrong");
  a_bad_flag: assert property (up == 2'h3 |-> cal_bad == ($past(cal_b_count) < 6'h03 ||
    {$past(cal_b_count), 2'h0} + 8'($past(cal_a_count)) < 8'h10))
    else $error("calibration divider fault flag wrong");
  a_busy_rise: assert property ($rose(cal_busy) |->
    $past(reg_wr && reg_addr == clkdist_pkg::ADDR_COMMIT && reg_wdata[0], 2))
    else $error("calibration started without a commit two cycles before");
  a_busy_len: assert property ($fell(cal_busy) |-> $past(pfd_tick) && ticks == CAL_PFD_PERIODS)
    else $error("calibration length wrong");
  a_no_retrig: assert property ($fell(cal_busy) |=> !cal_busy)
    else $error("calibration restarted at once");
  a_status_read: assert property (reg_rd && reg_addr == clkdist_pkg::ADDR_STATUS |=>
    reg_rdata[clkdist_pkg::BIT_BUSY] == $past(cal_busy))
    else $error("status busy bit differs from busy");
  a_held_uncal: assert property (!seen |-> output_channel == '0)
    else $error("output before first calibration");
  a_fine_copy: assert property (up == 2'h3 |-> fine_en_out == $past(ch_fine_en) &&
    fine_code_out == $past(ch_fine_code))
    else $error("fine delay controls not passed on");
endmodule : vco_cal_sync_asserts
bind vco_cal_and_output_divider_sync vco_cal_sync_asserts #(
  .NUM_CH(NUM_CH), .CAL_PFD_PERIODS(CAL_PFD_PERIODS)
) chk_u (
  .clk(clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pfd_tick(pfd_tick), .ch_fine_en(ch_fine_en),
  .ch_fine_code(ch_fine_code), .cal_b_count(cal_b_count), .cal_a_count(cal_a_count),
  .output_channel(output_channel), .fine_en_out(fine_en_out), .fine_code_out(fine_code_out),
  .cal_busy(cal_busy), .cal_bad(cal_bad), .cal_divider_value(cal_divider_value)
);

// ### vco_cal_and_output_divider_sync_tb.sv
// Purpose: register-driven tests of calibration, dividers, sync and power-down
// Assumes: calibration shortened to 20 pfd ticks, one tick every 4 cycles
// Notes: inputs change at the falling edge
`timescale 1ns/1ns
module vco_cal_and_output_divider_sync_tb;
  localparam int PER = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic pfd_tick;
  logic pll2_locked;
  logic lock_req = 1'b0;
  logic [13:0][1:0] ch_source = '0;
  logic pll1_level = 1'b0;
  logic sysref_level = 1'b0;
  logic [13:0][7:0] ch_divide = {14{8'h01}};
  logic [13:0][5:0] ch_coarse = '0;
  logic [13:0] ch_fine_en = '0;
  logic [13:0][3:0] ch_fine_code = '0;
  logic [5:0] cal_b_count = 6'h04;
  logic [1:0] cal_a_count = 2'h0;
  logic [13:0] output_channel;
  logic [13:0] fine_en_out;
  logic [13:0][3:0] fine_code_out;
  logic [13:0] regulator_pd;
  logic [13:0] half_step;
  logic cal_busy;
  logic cal_bad;
  logic [7:0] cal_divider_value;
  logic [5:0] bv [4] = '{6'h03, 6'h04, 6'h02, 6'h3f};
  logic [1:0] av [4] = '{2'h3, 2'h0, 2'h3, 2'h3};
  int error_cnt = 0;
  int check_count = 0;
  always #2 clk = ~clk;
  pll2_side_model #(.PERIOD(PER)) pll_u (.clk(clk), .arst_n(arst_n), .lock_req(lock_req),
    .pfd_tick(pfd_tick), .pll2_locked(pll2_locked));
  vco_cal_and_output_divider_sync #(.CAL_PFD_PERIODS(20)) dut_u (.clk(clk), .arst_n(arst_n),
    .ce(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pfd_tick(pfd_tick), .pll2_locked(pll2_locked), .pll1_level(pll1_level),
    .sysref_level(sysref_level), .ch_source(ch_source), .ch_divide(ch_divide), .ch_coarse(ch_coarse),
    .ch_fine_en(ch_fine_en), .ch_fine_code(ch_fine_code), .cal_b_count(cal_b_count),
    .cal_a_count(cal_a_count), .output_channel(output_channel), .fine_en_out(fine_en_out),
    .fine_code_out(fine_code_out), .half_step(half_step), .regulator_pd(regulator_pd),
    .cal_busy(cal_busy), .cal_bad(cal_bad), .cal_divider_value(cal_divider_value));
  // ===========================================
  // tasks
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string n);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    @(negedge clk);
    chk(n, {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  task automatic commit;
    wr(clkdist_pkg::ADDR_COMMIT, 8'h01);
  endtask : commit
  // counts high samples of one channel over a span
  task automatic highs(input int ch, input int span, input int e, input string n);
    int h;
    h = 0;
    repeat (span) begin
      @(negedge clk);
      if (output_channel[ch] === 1'b1) h++;
    end
    chk(n, 16'(e), 16'(h));
  endtask : highs
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (cal_busy !== v && n < 200) begin
      @(negedge clk);
      n++;
    end
    chk("cal_busy", {15'h0, v}, {15'h0, cal_busy});
  endtask : wait_busy
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  // ===========================================
  // tests
  initial begin
    int n;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk("outputs", 16'h0, {2'b0, output_channel});
    rd(clkdist_pkg::ADDR_STATUS, 8'h00, "status");
    wr(clkdist_pkg::ADDR_STATUS, 8'hff);
    rd(clkdist_pkg::ADDR_STATUS, 8'h00, "status ro");
    rd(16'h0100, 8'h00, "unmapped");
    wr(clkdist_pkg::ADDR_MASK_LO, 8'ha5);
    rd(clkdist_pkg::ADDR_MASK_LO, 8'ha5, "mask lo");
    wr(clkdist_pkg::ADDR_MASK_LO, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cal_b_count = bv[i];
      cal_a_count = av[i];
      repeat (2) @(negedge clk);
      chk("cal div", {8'h0, 8'(4 * bv[i] + av[i])}, {8'h0, cal_divider_value});
      chk("cal bad", {15'h0, (bv[i] < 6'h03 || 4 * bv[i] + av[i] < 16)}, {15'h0, cal_bad});
    end
    $display("test registers done");
    ch_divide[0] = 8'h03;
    ch_divide[1] = 8'h02;
    ch_divide[2] = 8'h00;
    ch_divide[4] = 8'h03;
    ch_coarse[4] = 6'h04;
    ch_coarse[5] = 6'h01;
    wr(clkdist_pkg::ADDR_CAL, 8'h01);
    commit;
    repeat (2) @(negedge clk);
    chk("busy", 16'h1, {15'h0, cal_busy});
    rd(clkdist_pkg::ADDR_STATUS, 8'h01, "status busy");
    highs(0, 8, 0, "held");
    wait_busy(1'b0);
    rd(clkdist_pkg::ADDR_STATUS, 8'h00, "status idle");
    repeat (4) @(negedge clk);
    highs(0, 16, 8, "ratio 4");
    highs(1, 12, 8, "ratio 3");
    highs(2, 4, 4, "ratio 1");
    commit;
    repeat (4) @(negedge clk);
    chk("no retrigger", 16'h0, {15'h0, cal_busy});
    wr(clkdist_pkg::ADDR_CAL, 8'h00);
    commit;
    wr(clkdist_pkg::ADDR_CAL, 8'h01);
    commit;
    repeat (2) @(negedge clk);
    chk("busy again", 16'h1, {15'h0, cal_busy});
    wait_busy(1'b0);
    $display("test calibration done");
    wr(clkdist_pkg::ADDR_MASK_LO, 8'h02);
    commit;
    wr(clkdist_pkg::ADDR_SYNC, 8'h01);
    commit;
    repeat (2) @(negedge clk);
    highs(0, 8, 0, "sync blank");
    highs(1, 12, 8, "ignored runs");
    wr(clkdist_pkg::ADDR_SYNC, 8'h00);
    commit;
    n = 0;
    while (output_channel[0] !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk("align", 16'h1, {15'h0, output_channel[3]});
    chk("coarse early", 16'h0, {15'h0, output_channel[4]});
    repeat (2) @(negedge clk);
    chk("coarse late", 16'h1, {15'h0, output_channel[4]});
    chk("half step", 16'h0020, {2'b0, half_step});
    $display("test sync done");
    wr(clkdist_pkg::ADDR_PD_LO, 8'h01);
    wr(clkdist_pkg::ADDR_LDO_HI, 8'h20);
    commit;
    highs(0, 8, 0, "powered down");
    chk("regulator", 16'h2000, {2'b0, regulator_pd});
    rd(clkdist_pkg::ADDR_PD_LO, 8'h01, "pd readback");
    ch_fine_en = 14'h2001;
    ch_fine_code[0] = 4'hf;
    repeat (2) @(negedge clk);
    chk("fine en", 16'h2001, {2'b0, fine_en_out});
    chk("fine code", 16'h000f, {12'h000, fine_code_out[0]});
    lock_req = 1'b1;
    // lock reaches the dividers after two model and two synchroniser stages
    repeat (6) @(negedge clk);
    chk("lock align", 16'h3, {14'h0, output_channel[1], output_channel[3]});
    @(negedge clk);
    chk("lock phase", 16'h2, {14'h0, output_channel[1], output_channel[3]});
    repeat (3) @(negedge clk);
    highs(1, 12, 8, "after lock");
    ch_source[5] = clkdist_pkg::SRC_PLL1;
    ch_source[6] = clkdist_pkg::SRC_SYSREF;
    pll1_level = 1'b1;
    sysref_level = 1'b1;
    repeat (8) @(negedge clk);
    chk("sources high", 16'h3, {14'h0, output_channel[6:5]});
    pll1_level = 1'b0;
    sysref_level = 1'b0;
    repeat (8) @(negedge clk);
    chk("sources low", 16'h0, {14'h0, output_channel[6:5]});
    $display("test power and lock done");
    results();
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule : vco_cal_and_output_divider_sync_tb
